// *** core/occ_channel.sv ***
/*
 Output compare channel with its own timer, APB register slave and interrupt.
 Assumes timer clock ticks arrive as one-cycle pulses synchronous to pclk,
 and idle and fault inputs are synchronous levels.
*/
// The address map and the APB slave port are this design's own decisions.
// Behaviour
// RULE1 - Three-bit select picks the timer tick source
// RULE2 - Idle-stop bit halts channel during CPU idle
// RULE3 - Compare timer with one or two registers
// RULE4 - Compare matches can raise an interrupt
// RULE5 - Fault input acts only when enabled
// RULE6 - Trigger flag cleared by secondary match optionally
// RULE7 - Compare registers double-buffered only in PWM
// RULE8 - Centre PWM: high at primary, low secondary
// RULE9 - Edge PWM: high at zero, low primary
// RULE10 - Dual continuous: start low, alternate toggles
// RULE11 - Dual single-shot: low, toggle twice, one pulse
// RULE12 - Single compare toggles on every primary match
// RULE13 - Mode two: start high, low on match
// RULE14 - Mode one: start low, high on match
// RULE15 - Mode zero disables all compare activity
// RULE16 - Enabled fault sets sticky software-clearable status
// RULE17 - Timer counts selected ticks, restarts per period
`timescale 1ns/10ps
module occ_channel
    import occ_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire occ_pkg::occ_apb_req_type apb_req,
    output occ_pkg::occ_apb_rsp_type apb_rsp,
    input wire occ_pkg::occ_tick_type timer_tick,
    input wire logic cpu_idle,
    input wire logic fault_a_input,
    output logic compare_output_pin,
    output logic irq
);
    import occ_pkg::*;

    logic [15:0] ctrl;
    logic [15:0] primary_write;
    logic [15:0] secondary_write;
    logic [15:0] primary_compare_value;
    logic [15:0] secondary_compare_value;
    logic [15:0] channel_timer;
    logic [OCC_STAT_W-1:0] irq_status;
    logic [OCC_STAT_W-1:0] irq_mask;
    logic fault_a_status;
    logic trigger_status_flag;
    logic shot_done;
    logic dual_phase;
    logic [2:0] last_mode;

    occ_mode_type compare_mode_field;
    logic [2:0] timebase_clock_select;
    logic idle_stop_bit;
    logic fault_a_enable;
    logic trigger_clear_mode;
    logic tick;
    logic run;
    logic is_pwm;
    logic match_primary;
    logic match_secondary;
    logic fault_event;
    logic mode_changed;
    logic wr_en;
    logic rd_en;
    logic [15:0] wdata16;
    logic [15:0] next_timer;
    logic [OCC_STAT_W-1:0] events;
    logic [31:0] read_data;

    function automatic logic hits(input logic [OCC_ADDR_W-1:0] a, input logic [4:0] off);
        hits = (a == off);
    endfunction : hits

    assign compare_mode_field = occ_mode_type'(ctrl[2:0]);
    assign timebase_clock_select = ctrl[OCC_CLKSEL_LSB+2:OCC_CLKSEL_LSB];
    assign idle_stop_bit = ctrl[OCC_IDLE_STOP_BIT];
    assign fault_a_enable = ctrl[OCC_FAULT_EN_BIT];
    assign trigger_clear_mode = ctrl[OCC_TRIG_MODE_BIT];
    assign is_pwm = (compare_mode_field == OCC_MODE_EDGE_PWM) || (compare_mode_field == OCC_MODE_CENTRE_PWM);
    assign mode_changed = (last_mode != ctrl[2:0]);

    // Reserved selects give no ticks, so the timer simply stands
    always_comb begin
        case (timebase_clock_select) // [RULE1]
            OCC_CLK_TIMER2: tick = timer_tick.timer2;
            OCC_CLK_TIMER3: tick = timer_tick.timer3;
            OCC_CLK_TIMER4: tick = timer_tick.timer4;
            OCC_CLK_TIMER5: tick = timer_tick.timer5;
            OCC_CLK_TIMER1: tick = timer_tick.timer1;
            OCC_CLK_PERIPH: tick = 1'b1;
            default: tick = 1'b0;
        endcase
    end

    assign run = (compare_mode_field != OCC_MODE_OFF) && !(idle_stop_bit && cpu_idle); // [RULE2] [RULE15]
    assign match_primary = run && tick && (channel_timer == primary_compare_value); // [RULE3]
    assign match_secondary = run && tick && (channel_timer == secondary_compare_value); // [RULE3]
    assign fault_event = fault_a_enable && fault_a_input; // [RULE5]

    // Period ends at the secondary value in PWM, so it is the period register
    always_comb begin
        next_timer = channel_timer + OCC_COUNT_ONE;
        if (is_pwm && (channel_timer == secondary_compare_value)) begin
            next_timer = OCC_COUNT_ZERO; // [RULE17]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_timer <= OCC_COUNT_ZERO;
        end else if (compare_mode_field == OCC_MODE_OFF || mode_changed) begin
            channel_timer <= OCC_COUNT_ZERO;
        end else if (run && tick) begin
            channel_timer <= next_timer; // [RULE17]
        end
    end

    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en = apb_req.psel && !apb_req.pwrite;
    assign wdata16 = apb_req.pwdata[15:0];

    // Control register; hardware-owned bits are masked out of the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= OCC_CTRL_RESET;
            last_mode <= 3'h0;
        end else begin
            last_mode <= ctrl[2:0];
            if (wr_en && hits(apb_req.paddr, OCC_CTRL_OFFSET)) begin
                ctrl <= wdata16 & OCC_CTRL_WR_MASK;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_write <= OCC_COUNT_ZERO;
            secondary_write <= OCC_COUNT_ZERO;
        end else if (wr_en) begin
            if (hits(apb_req.paddr, OCC_PRIMARY_OFFSET)) begin
                primary_write <= wdata16;
            end
            if (hits(apb_req.paddr, OCC_SECONDARY_OFFSET)) begin
                secondary_write <= wdata16;
            end
        end
    end

    // Shadow load at period end avoids glitched PWM duty on mid-period writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_compare_value <= OCC_COUNT_ZERO;
            secondary_compare_value <= OCC_COUNT_ZERO;
        end else if (!is_pwm || !run || (tick && next_timer == OCC_COUNT_ZERO)) begin
            primary_compare_value <= primary_write; // [RULE7]
            secondary_compare_value <= secondary_write; // [RULE7]
        end
    end

    // Output pin state per mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_pin <= 1'b0;
            shot_done <= 1'b0;
            dual_phase <= 1'b0;
        end else if (fault_event) begin
            compare_output_pin <= 1'b0; // [RULE5]
        end else if (compare_mode_field == OCC_MODE_OFF || mode_changed) begin
            compare_output_pin <= (compare_mode_field == OCC_MODE_ONE_LOW); // [RULE13] [RULE15]
            shot_done <= 1'b0;
            dual_phase <= 1'b0;
        end else begin
            case (compare_mode_field)
                OCC_MODE_ONE_HIGH: begin
                    if (match_primary) compare_output_pin <= 1'b1; // [RULE14]
                end
                OCC_MODE_ONE_LOW: begin
                    if (match_primary) compare_output_pin <= 1'b0; // [RULE13]
                end
                OCC_MODE_TOGGLE: begin
                    if (match_primary) compare_output_pin <= !compare_output_pin; // [RULE12]
                end
                OCC_MODE_DUAL_SHOT: begin
                    if (!shot_done && !dual_phase && match_primary) begin
                        compare_output_pin <= 1'b1; // [RULE11]
                        dual_phase <= 1'b1;
                    end else if (!shot_done && dual_phase && match_secondary) begin
                        compare_output_pin <= 1'b0; // [RULE11]
                        shot_done <= 1'b1;
                    end
                end
                OCC_MODE_DUAL_CONT: begin
                    if (!dual_phase && match_primary) begin
                        compare_output_pin <= !compare_output_pin; // [RULE10]
                        dual_phase <= 1'b1;
                    end else if (dual_phase && match_secondary) begin
                        compare_output_pin <= !compare_output_pin; // [RULE10]
                        dual_phase <= 1'b0;
                    end
                end
                OCC_MODE_EDGE_PWM: begin
                    if (run && tick && next_timer == OCC_COUNT_ZERO) begin
                        compare_output_pin <= 1'b1; // [RULE9]
                    end else if (match_primary) begin
                        compare_output_pin <= 1'b0; // [RULE9]
                    end
                end
                OCC_MODE_CENTRE_PWM: begin
                    if (match_secondary) begin
                        compare_output_pin <= 1'b0; // [RULE8]
                    end else if (match_primary) begin
                        compare_output_pin <= 1'b1; // [RULE8]
                    end
                end
                default: compare_output_pin <= 1'b0;
            endcase
        end
    end

    // Fault status: set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_a_status <= 1'b0;
        end else if (fault_event) begin
            fault_a_status <= 1'b1; // [RULE16]
        end else if (wr_en && hits(apb_req.paddr, OCC_CTRL_OFFSET) && !wdata16[OCC_FAULT_STAT_BIT]) begin
            fault_a_status <= 1'b0; // [RULE16]
        end
    end

    // Trigger flag is set by a primary match; software writes zero to clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_status_flag <= 1'b0;
        end else if (match_primary) begin
            trigger_status_flag <= 1'b1;
        end else if (trigger_clear_mode && match_secondary) begin
            trigger_status_flag <= 1'b0; // [RULE6]
        end else if (wr_en && hits(apb_req.paddr, OCC_CTRL_OFFSET) && !wdata16[OCC_TRIG_STAT_BIT]) begin
            trigger_status_flag <= 1'b0; // [RULE6]
        end
    end

    assign events = {fault_event, match_secondary, match_primary};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= OCC_STAT_RESET;
            irq_mask <= OCC_STAT_RESET;
        end else begin
            if (wr_en && hits(apb_req.paddr, OCC_STATUS_OFFSET)) begin
                irq_status <= (irq_status & ~apb_req.pwdata[OCC_STAT_W-1:0]) | events; // [RULE4]
            end else begin
                irq_status <= irq_status | events; // [RULE4]
            end
            if (wr_en && hits(apb_req.paddr, OCC_MASK_OFFSET)) begin
                irq_mask <= apb_req.pwdata[OCC_STAT_W-1:0];
            end
        end
    end

    assign irq = |(irq_status & irq_mask); // [RULE4]

    // Read data registered in setup so the access phase answers at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_data <= 32'h0000_0000;
        end else if (rd_en && !apb_req.penable) begin
            case (apb_req.paddr)
                OCC_CTRL_OFFSET: read_data <= {16'h0000, ctrl[15:6], trigger_status_flag,
                    fault_a_status, ctrl[3:0]};
                OCC_PRIMARY_OFFSET: read_data <= {16'h0000, primary_write};
                OCC_SECONDARY_OFFSET: read_data <= {16'h0000, secondary_write};
                OCC_TIMER_OFFSET: read_data <= {16'h0000, channel_timer};
                OCC_STATUS_OFFSET: read_data <= {29'h0000_0000, irq_status};
                OCC_MASK_OFFSET: read_data <= {29'h0000_0000, irq_mask};
                default: read_data <= 32'h0000_0000;
            endcase
        end
    end

    // One driver for the whole response
    assign apb_rsp = '{pready: 1'b1,
        pslverr: apb_req.psel && apb_req.penable &&
            (apb_req.paddr > OCC_MASK_OFFSET || apb_req.paddr[1:0] != 2'h0),
        prdata: read_data};

    // Mode settled: running, no reinit, no fault, no register write
    sequence s_steady(logic [2:0] m);
        run && !mode_changed && !fault_event && !wr_en && compare_mode_field == m;
    endsequence : s_steady

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
        (|(events & irq_mask)) && !(wr_en && hits(apb_req.paddr, OCC_MASK_OFFSET))
        |=> irq)
        else $error("irq not raised");
    a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
        (compare_mode_field == OCC_MODE_OFF) |=> channel_timer == OCC_COUNT_ZERO)
        else $error("timer ran off");
    a_idle_halt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
        (idle_stop_bit && cpu_idle && !mode_changed && !wr_en) |=> $stable(channel_timer))
        else $error("idle ran");
    a_fault_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
        fault_event |=> fault_a_status)
        else $error("fault not set");
    a_toggle_hit: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
        (compare_mode_field == OCC_MODE_TOGGLE && !mode_changed && match_primary && !fault_event && !wr_en)
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("no toggle");
    a_one_high: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
        (compare_mode_field == OCC_MODE_ONE_HIGH && !mode_changed && match_primary && !fault_event && !wr_en)
        |=> compare_output_pin)
        else $error("not high");
    a_centre_low: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        (compare_mode_field == OCC_MODE_CENTRE_PWM && !mode_changed && match_secondary && !wr_en)
        |=> !compare_output_pin)
        else $error("centre not low");
    a_trig_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        (trigger_status_flag && !trigger_clear_mode && !wr_en) |=> trigger_status_flag)
        else $error("trig lost");
    a_trig_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        (trigger_clear_mode && match_secondary && !match_primary)
        |=> !trigger_status_flag)
        else $error("trig not cleared");
    a_one_low: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
        s_steady(OCC_MODE_ONE_LOW) ##0 match_primary
        |=> !compare_output_pin)
        else $error("not low");
    a_init_high: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
        (mode_changed && !fault_event && compare_mode_field == OCC_MODE_ONE_LOW)
        |=> compare_output_pin)
        else $error("init not high");
    a_init_low: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10] [RULE11] [RULE14]
        (mode_changed && !fault_event
        && compare_mode_field inside {OCC_MODE_ONE_HIGH, OCC_MODE_DUAL_SHOT, OCC_MODE_DUAL_CONT})
        |=> !compare_output_pin)
        else $error("init not low");
    a_dual_first: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
        s_steady(OCC_MODE_DUAL_CONT) ##0 (match_primary && !dual_phase)
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("no dual toggle");
    a_shot_rise: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
        s_steady(OCC_MODE_DUAL_SHOT) ##0 (match_primary && !dual_phase && !shot_done)
        |=> compare_output_pin)
        else $error("shot not high");
    a_shot_once: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
        s_steady(OCC_MODE_DUAL_SHOT) ##0 shot_done
        |=> !compare_output_pin)
        else $error("second pulse");
    a_edge_rise: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        s_steady(OCC_MODE_EDGE_PWM) ##0 (tick && channel_timer == secondary_compare_value)
        |=> compare_output_pin)
        else $error("edge not high");
    a_edge_fall: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
        s_steady(OCC_MODE_EDGE_PWM) ##0 (match_primary && channel_timer < secondary_compare_value)
        |=> !compare_output_pin)
        else $error("edge not low");
    a_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
        (is_pwm && run && tick && channel_timer < secondary_compare_value)
        |=> $stable(primary_compare_value) && $stable(secondary_compare_value))
        else $error("shadow loaded early");
    a_timer_step: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
        (run && tick && !mode_changed && !is_pwm)
        |=> channel_timer == $past(channel_timer) + OCC_COUNT_ONE)
        else $error("timer step wrong");
    a_timer_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
        (run && tick && !mode_changed && is_pwm && channel_timer == secondary_compare_value)
        |=> channel_timer == OCC_COUNT_ZERO)
        else $error("timer no wrap");
    a_tick_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        (!mode_changed && timebase_clock_select == OCC_CLK_TIMER3 && !timer_tick.timer3)
        |=> $stable(channel_timer))
        else $error("unselected tick counted");
endmodule : occ_channel

// *** core/occ_pkg.sv ***
/*
 Package for the output compare channel: register map, control field layout,
 modes, clock selects and packed carriers.
 Assumes a 32-bit APB slave; registers sit one per aligned word.
*/
package occ_pkg;
    localparam int unsigned OCC_ADDR_W = 5;
    localparam logic [4:0] OCC_CTRL_OFFSET = 5'h00;
    localparam logic [4:0] OCC_PRIMARY_OFFSET = 5'h04;
    localparam logic [4:0] OCC_SECONDARY_OFFSET = 5'h08;
    localparam logic [4:0] OCC_TIMER_OFFSET = 5'h0C;
    localparam logic [4:0] OCC_STATUS_OFFSET = 5'h10;
    localparam logic [4:0] OCC_MASK_OFFSET = 5'h14;

    localparam int unsigned OCC_IDLE_STOP_BIT = 13;
    localparam int unsigned OCC_CLKSEL_LSB = 10;
    localparam int unsigned OCC_FAULT_EN_BIT = 7;
    localparam int unsigned OCC_FAULT_STAT_BIT = 4;
    localparam int unsigned OCC_TRIG_MODE_BIT = 3;
    localparam int unsigned OCC_TRIG_STAT_BIT = 5;

    localparam int unsigned OCC_STAT_PRIMARY = 0;
    localparam int unsigned OCC_STAT_SECONDARY = 1;
    localparam int unsigned OCC_STAT_FAULT = 2;
    localparam int unsigned OCC_STAT_W = 3;

    localparam logic [15:0] OCC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] OCC_CTRL_WR_MASK = 16'h3C8F;
    localparam logic [15:0] OCC_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] OCC_COUNT_ONE = 16'h0001;
    localparam logic [2:0] OCC_STAT_RESET = 3'h0;

    typedef enum logic [2:0] {
        OCC_MODE_OFF = 3'h0,
        OCC_MODE_ONE_HIGH = 3'h1,
        OCC_MODE_ONE_LOW = 3'h2,
        OCC_MODE_TOGGLE = 3'h3,
        OCC_MODE_DUAL_SHOT = 3'h4,
        OCC_MODE_DUAL_CONT = 3'h5,
        OCC_MODE_EDGE_PWM = 3'h6,
        OCC_MODE_CENTRE_PWM = 3'h7
    } occ_mode_type;

    localparam logic [2:0] OCC_CLK_TIMER2 = 3'h0;
    localparam logic [2:0] OCC_CLK_TIMER3 = 3'h1;
    localparam logic [2:0] OCC_CLK_TIMER4 = 3'h2;
    localparam logic [2:0] OCC_CLK_TIMER5 = 3'h3;
    localparam logic [2:0] OCC_CLK_TIMER1 = 3'h4;
    localparam logic [2:0] OCC_CLK_PERIPH = 3'h7;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [OCC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } occ_apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } occ_apb_rsp_type;

    typedef struct packed {
        logic timer1;
        logic timer2;
        logic timer3;
        logic timer4;
        logic timer5;
    } occ_tick_type;
endpackage : occ_pkg

// *** tb/occ_load.sv ***
/*
 Load model on the compare pin: counts rising edges, last high width and
 rise-to-rise period in pclk cycles.
 Assumes the pin is a registered output of the channel, clocked by pclk.
*/
`timescale 1ns/10ps
module occ_load (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output int rises,
    output int high_len,
    output int period
);
    logic last;
    int hi;
    int per;

    // Passive load: it only watches, so it cannot disturb the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 1'b0;
            rises <= 0;
            high_len <= 0;
            period <= 0;
            hi <= 0;
            per <= 0;
        end else begin
            last <= pin;
            per <= per + 1;
            hi <= hi + 1;
            if (pin && !last) begin
                rises <= rises + 1;
                period <= per;
                per <= 1;
                hi <= 1;
            end
            if (!pin && last) begin
                high_len <= hi;
            end
        end
    end
endmodule : occ_load

// *** tb/tb_output_compare_channel.sv ***
/*
 Testbench for the output compare channel: APB tasks, pin load model.
 Assumes zero-wait APB slave and ticks synchronous to pclk.
*/
`timescale 1ns/10ps
module tb_output_compare_channel;
    import occ_pkg::*;
    localparam logic [31:0] PER = 32'h1C00;
    logic pclk;
    logic presetn;
    occ_apb_req_type req;
    occ_apb_rsp_type rsp;
    occ_tick_type tick;
    logic idle;
    logic fault;
    logic pin;
    logic irq;
    int fails;
    int num_checks;
    int cycles;
    int rises;
    int high_len;
    int period;
    int r0;
    logic [31:0] v;
    logic [31:0] t;
    logic [4:0] bsel;
    logic err;

    occ_channel dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .timer_tick(tick),
        .cpu_idle(idle), .fault_a_input(fault), .compare_output_pin(pin), .irq(irq));
    occ_load load (.pclk(pclk), .presetn(presetn), .pin(pin), .rises(rises), .high_len(high_len),
        .period(period));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Request held until pready is sampled high; no wait count assumed
    task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        v = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic wait_pin(input logic lvl, input int lim);
        int n;
        n = 0;
        while (pin !== lvl && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("pin", {31'h0, pin}, {31'h0, lvl});
    endtask : wait_pin

    // Mode 0 first so the new mode always reinitialises the timer
    task automatic setup(input logic [31:0] p, input logic [31:0] s, input logic [31:0] c);
        apb(1'b1, OCC_CTRL_OFFSET, 32'h0);
        apb(1'b1, OCC_PRIMARY_OFFSET, p);
        apb(1'b1, OCC_SECONDARY_OFFSET, s);
        apb(1'b1, OCC_STATUS_OFFSET, 32'h7);
        apb(1'b1, OCC_CTRL_OFFSET, c);
    endtask : setup

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        presetn = 1'b0;
        req = '0;
        tick = '0;
        idle = 1'b0;
        fault = 1'b0;
        fails = 0;
        num_checks = 0;
        cycles = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OCC_CTRL_OFFSET, 32'h0);
        chk("ctrl reset", v, 32'h0);
        apb(1'b0, 5'h18, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", v, 32'h0);
        apb(1'b1, OCC_CTRL_OFFSET, PER);
        cyc(20);
        apb(1'b0, OCC_TIMER_OFFSET, 32'h0);
        chk("timer off", v, 32'h0);
        chk("pin off", {31'h0, pin}, 32'h0);
        $display("test reset and disabled done");
        setup(32'h14, 32'hFFFF, PER | 32'h1);
        chk("pin init", {31'h0, pin}, 32'h0);
        wait_pin(1'b1, 60);
        apb(1'b0, OCC_STATUS_OFFSET, 32'h0);
        chk("match status", v & 32'h1, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, OCC_MASK_OFFSET, 32'h1);
        cyc(1);
        chk("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, OCC_STATUS_OFFSET, 32'h1);
        cyc(1);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        setup(32'h14, 32'hFFFF, PER | 32'h2);
        wait_pin(1'b1, 5);
        wait_pin(1'b0, 60);
        setup(32'hFFFF, 32'hFFFF, PER | 32'h1);
        apb(1'b1, OCC_PRIMARY_OFFSET, 32'h32);
        wait_pin(1'b1, 80);
        setup(32'h14, 32'hFFFF, PER | 32'h3);
        wait_pin(1'b1, 60);
        $display("test single compare done");
        setup(32'hA, 32'h14, PER | 32'hC);
        r0 = rises;
        cyc(150);
        chk("one pulse", rises - r0, 32'h1);
        chk("pulse width", high_len, 32'hA);
        apb(1'b0, OCC_CTRL_OFFSET, 32'h0);
        chk("trig hw clear", v, PER | 32'hC);
        setup(32'hA, 32'h14, PER | 32'h4);
        cyc(100);
        apb(1'b0, OCC_CTRL_OFFSET, 32'h0);
        chk("trig kept", v, PER | 32'h24);
        apb(1'b1, OCC_CTRL_OFFSET, PER | 32'h4);
        apb(1'b0, OCC_CTRL_OFFSET, 32'h0);
        chk("trig sw clear", v, PER | 32'h4);
        setup(32'hA, 32'h14, PER | 32'h5);
        cyc(60);
        chk("cont width", high_len, 32'hA);
        $display("test dual compare done");
        setup(32'hA, 32'h28, PER | 32'h6);
        cyc(130);
        chk("edge period", period, 32'h29);
        chk("edge high", high_len, 32'hB);
        apb(1'b1, OCC_PRIMARY_OFFSET, 32'h1E);
        cyc(130);
        chk("edge new high", high_len, 32'h1F);
        setup(32'hA, 32'h1E, PER | 32'h7);
        cyc(100);
        chk("centre period", period, 32'h1F);
        chk("centre high", high_len, 32'h14);
        $display("test pwm done");
        setup(32'hA, 32'h28, PER | 32'h86);
        cyc(50);
        fault <= 1'b1;
        cyc(3);
        chk("fault pin", {31'h0, pin}, 32'h0);
        apb(1'b0, OCC_CTRL_OFFSET, 32'h0);
        chk("fault flag", v, PER | 32'hB6);
        apb(1'b0, OCC_STATUS_OFFSET, 32'h0);
        chk("fault status", v & 32'h4, 32'h4);
        fault <= 1'b0;
        apb(1'b1, OCC_CTRL_OFFSET, PER | 32'h86);
        apb(1'b0, OCC_CTRL_OFFSET, 32'h0);
        chk("fault cleared", v, PER | 32'h86);
        setup(32'hA, 32'h28, PER | 32'h6);
        fault <= 1'b1;
        r0 = rises;
        cyc(100);
        chk("fault ignored", {31'h0, rises - r0 >= 2}, 32'h1);
        apb(1'b0, OCC_STATUS_OFFSET, 32'h0);
        chk("no fault status", v & 32'h4, 32'h0);
        fault <= 1'b0;
        $display("test fault done");
        setup(32'hFFFF, 32'hFFFF, PER | 32'h2003);
        cyc(5);
        idle <= 1'b1;
        apb(1'b0, OCC_TIMER_OFFSET, 32'h0);
        t = v;
        cyc(10);
        apb(1'b0, OCC_TIMER_OFFSET, 32'h0);
        chk("idle halt", v, t);
        apb(1'b1, OCC_CTRL_OFFSET, PER | 32'h3);
        apb(1'b0, OCC_TIMER_OFFSET, 32'h0);
        t = v;
        cyc(10);
        apb(1'b0, OCC_TIMER_OFFSET, 32'h0);
        chk("idle run", {31'h0, v != t}, 32'h1);
        idle <= 1'b0;
        $display("test idle done");
        // Unselected sources tick every cycle to show they are ignored
        for (int s = 0; s < 6; s++) begin
            bsel = (s == 4) ? 5'h10 : (s == 5) ? 5'h00 : (5'h08 >> s);
            setup(32'hFFFF, 32'hFFFF, (32'(s) << OCC_CLKSEL_LSB) | 32'h3);
            cyc(3);
            repeat (5) begin
                @(posedge pclk);
                tick <= occ_tick_type'(5'h1F);
                @(posedge pclk);
                tick <= occ_tick_type'(5'h1F ^ bsel);
            end
            @(posedge pclk);
            tick <= '0;
            apb(1'b0, OCC_TIMER_OFFSET, 32'h0);
            chk("tick source", v, (s == 5) ? 32'h0 : 32'h5);
        end
        $display("test clock select done");
        stop_test();
    end
endmodule : tb_output_compare_channel
